// ---- verilog/spcr_bank.sv ----
// Purpose: Base configuration registers of the converter behind a four-wire serial port.
// Assumes: Serial pins are synchronous to i_clk and the serial clock is well below i_clk/4.
// Notes: Mode 0 framing: 16-bit instruction (read flag, 15-bit address), then data bytes.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_params.svh"
// Summary of operation
// - Writing one to config bit 7 resets the chip and every register.
// - The soft reset bit clears itself once the reset is done.
// - The soft reset completes within 750 ns of the setting write.
// - Config bit 5, reset one, selects ascending else descending streaming addresses.
// - Config bit 4 always reads one; reads use only the separate output line.
// - Mode field 0 is normal operation, 3 is power down; 1 and 2 reserved.
// - Device-class bits 3:0 always return the fixed class code.
// - After any reset the interface config register reads 0x30.
// - After any reset the power-state register reads 0x00.
// - Fixed-address streaming bit holds the address; otherwise direction bit steps.
module spcr_bank (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Serial port.
   input wire logic i_sclk,
   input wire logic i_cs_n,
   input wire logic i_sdi,
   output logic o_sdo,
   output logic o_sdo_oe_n,
   // Chip control.
   output logic o_chip_reset,
   output logic o_power_down,
   output logic [1:0] o_operating_mode
);
   import spcr_pkg::*;

   spcr_pkg::spcr_phase_t phase;
   logic sclk_q;
   logic [4:0] bit_cnt;
   logic [15:0] shreg;
   logic [14:0] addr;
   logic is_read;
   logic [7:0] tx;
   logic [7:0] srst_cnt;
   logic [7:0] cfg_q;
   logic [7:0] pwr_q;
   logic [7:0] class_q;
   logic [7:0] hold_q;
   logic rise;
   logic fall;
   logic [15:0] next_shreg;
   logic instr_done;
   logic data_done;
   logic wr_en;
   logic srst_req;
   logic [14:0] next_addr;
   logic [7:0] cfg_rd;
   logic [7:0] class_rd;

   // Serial clock edges seen in the system clock domain.
   assign rise = i_sclk && !sclk_q;
   assign fall = !i_sclk && sclk_q;
   assign next_shreg = {shreg[14:0], i_sdi};
   assign instr_done = rise && (phase == SPCR_INSTR) && (bit_cnt == `SPCR_INSTR_LAST);
   assign data_done = rise && (phase == SPCR_DATA) && (bit_cnt == `SPCR_BYTE_LAST);
   assign wr_en = data_done && !is_read;
   assign srst_req = wr_en && (addr == `SPCR_ADDR_CFG) && next_shreg[`SPCR_BIT_SRST];

   // Address stepping for streaming transfers.
   always_comb
   begin
      if (hold_q[`SPCR_BIT_HOLD])
         next_addr = addr;
      else if (cfg_q[`SPCR_BIT_ASCEND])
         next_addr = 15'(addr + 15'h0001);
      else
         next_addr = 15'(addr - 15'h0001);
   end

   // Read views: bit 7 shows a soft reset still running, bit 4 is hard-wired high.
   assign cfg_rd = {o_chip_reset, cfg_q[6:5], 1'b1, cfg_q[3:0]};
   assign class_rd = {class_q[7:4], `SPCR_CLASS_CODE};

   // Read data mux; unmapped addresses return zero.
   function automatic logic [7:0] read_reg(input logic [14:0] a);
      logic [7:0] d;
      d = `SPCR_RD_UNMAPPED;
      if (a == `SPCR_ADDR_CFG)
         d = cfg_rd;
      else if (a == `SPCR_ADDR_PWR)
         d = pwr_q;
      else if (a == `SPCR_ADDR_CLASS)
         d = class_rd;
      else if (a == `SPCR_ADDR_HOLD)
         d = hold_q;
      return d;
   endfunction

   // Serial clock history for edge detection.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         sclk_q <= 1'b0;
      else
         sclk_q <= i_sclk;
   end

   // Frame engine. It stays idle during a soft reset, because the host
   // must leave the port alone then and any half frame would be garbage.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         phase <= SPCR_INSTR;
         bit_cnt <= 5'h00;
         shreg <= 16'h0000;
         addr <= 15'h0000;
         is_read <= 1'b0;
      end
      else if (i_cs_n || o_chip_reset)
      begin
         phase <= SPCR_INSTR;
         bit_cnt <= 5'h00;
      end
      else if (rise)
      begin
         shreg <= next_shreg;
         case (phase)
            SPCR_INSTR:
            begin
               if (bit_cnt == `SPCR_INSTR_LAST)
               begin
                  is_read <= next_shreg[`SPCR_BIT_RW];
                  addr <= next_shreg[14:0];
                  phase <= SPCR_DATA;
                  bit_cnt <= 5'h00;
               end
               else
                  bit_cnt <= 5'(bit_cnt + 5'h01);
            end
            SPCR_DATA:
            begin
               if (bit_cnt == `SPCR_BYTE_LAST)
               begin
                  addr <= next_addr;
                  bit_cnt <= 5'h00;
               end
               else
                  bit_cnt <= 5'(bit_cnt + 5'h01);
            end
            default:
               phase <= SPCR_INSTR;
         endcase
      end
   end

   // Read path: load a byte at each byte boundary, shift out on falling edges.
   // Only the dedicated output line is ever driven with read data.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         tx <= 8'h00;
         o_sdo <= 1'b0;
      end
      else if (instr_done)
         tx <= read_reg(next_shreg[14:0]);
      else if (data_done)
         tx <= read_reg(next_addr);
      else if (fall && (phase == SPCR_DATA) && !i_cs_n)
      begin
         o_sdo <= tx[7];
         tx <= {tx[6:0], 1'b0};
      end
   end

   // Output enable follows chip select so the line is released between frames.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_sdo_oe_n <= 1'b1;
      else
         o_sdo_oe_n <= i_cs_n;
   end

   // Soft reset window: the pulse is sized so it ends within the allowed time.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_chip_reset <= 1'b0;
         srst_cnt <= `SPCR_CNT_ZERO;
      end
      else if (srst_req && !o_chip_reset)
      begin
         o_chip_reset <= 1'b1;
         srst_cnt <= `SPCR_SRST_LOAD;
      end
      else if (o_chip_reset)
      begin
         if (srst_cnt == `SPCR_CNT_ZERO)
            o_chip_reset <= 1'b0;
         else
            srst_cnt <= 8'(srst_cnt - `SPCR_CNT_ONE);
      end
   end

   // Registers; all are cleared for the whole soft reset window.
   spcr_reg8 #(.RESET_VAL(`SPCR_RST_CFG)) u_cfg (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_clr(o_chip_reset),
      .i_we(wr_en && (addr == `SPCR_ADDR_CFG)),
      .i_wdata(next_shreg[7:0]),
      .o_q(cfg_q)
   );
   spcr_reg8 #(.RESET_VAL(`SPCR_RST_PWR)) u_pwr (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_clr(o_chip_reset),
      .i_we(wr_en && (addr == `SPCR_ADDR_PWR)),
      .i_wdata(next_shreg[7:0]),
      .o_q(pwr_q)
   );
   spcr_reg8 #(.RESET_VAL(`SPCR_RST_CLASS)) u_class (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_clr(o_chip_reset),
      .i_we(wr_en && (addr == `SPCR_ADDR_CLASS)),
      .i_wdata(next_shreg[7:0]),
      .o_q(class_q)
   );
   spcr_reg8 #(.RESET_VAL(`SPCR_RST_HOLD)) u_hold (
      .i_clk(i_clk),
      .i_arst_n(i_arst_n),
      .i_clr(o_chip_reset),
      .i_we(wr_en && (addr == `SPCR_ADDR_HOLD)),
      .i_wdata(next_shreg[7:0]),
      .o_q(hold_q)
   );

   // Operating state outputs; reserved codes pass through as written.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
      begin
         o_operating_mode <= `SPCR_MODE_NORMAL;
         o_power_down <= 1'b0;
      end
      else
      begin
         o_operating_mode <= pwr_q[1:0];
         o_power_down <= (pwr_q[1:0] == `SPCR_MODE_PDOWN);
      end
   end

   // Checks.
   localparam int SRST_MAX = `SPCR_SRST_CYC - 1;
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_arst_n);

   a_srst_start: assert property (srst_req |=> o_chip_reset)
      else $error("soft reset did not start");
   a_srst_bound: assert property ($rose(o_chip_reset) |-> ##[1:SRST_MAX] !o_chip_reset)
      else $error("soft reset too long");
   a_srst_selfclr: assert property ($fell(o_chip_reset)
      |-> !cfg_q[`SPCR_BIT_SRST] && !cfg_rd[`SPCR_BIT_SRST])
      else $error("soft reset bit did not clear");
   a_srst_clears: assert property (o_chip_reset |=> cfg_q == `SPCR_RST_CFG
      && pwr_q == `SPCR_RST_PWR && hold_q == `SPCR_RST_HOLD && class_q == `SPCR_RST_CLASS)
      else $error("register survived soft reset");
   a_cfg_after_rst: assert property ($fell(o_chip_reset) |-> cfg_rd == `SPCR_RST_CFG)
      else $error("config not at reset value");
   a_pwr_after_rst: assert property ($fell(o_chip_reset) |-> pwr_q == `SPCR_RST_PWR)
      else $error("power state not at reset value");
   // Read-path checks look at the shifter one cycle after it is loaded.
   a_flag_high: assert property ((instr_done && !i_cs_n && !o_chip_reset
      && next_shreg[14:0] == `SPCR_ADDR_CFG) |=> tx[`SPCR_BIT_OUTFLAG])
      else $error("separate output flag low");
   a_class_code: assert property ((instr_done && !i_cs_n && !o_chip_reset
      && next_shreg[14:0] == `SPCR_ADDR_CLASS) |=> tx[3:0] == `SPCR_CLASS_CODE)
      else $error("class code wrong");
   a_addr_ascend: assert property ((data_done && !i_cs_n && !o_chip_reset
      && !hold_q[`SPCR_BIT_HOLD] && cfg_q[`SPCR_BIT_ASCEND])
      |=> addr == 15'($past(addr) + 15'h0001))
      else $error("ascending step wrong");
   a_addr_descend: assert property ((data_done && !i_cs_n && !o_chip_reset
      && !hold_q[`SPCR_BIT_HOLD] && !cfg_q[`SPCR_BIT_ASCEND])
      |=> addr == 15'($past(addr) - 15'h0001))
      else $error("descending step wrong");
   a_addr_hold: assert property ((data_done && !i_cs_n && !o_chip_reset
      && hold_q[`SPCR_BIT_HOLD]) |=> addr == $past(addr))
      else $error("held address moved");
   a_pdown_map: assert property ((pwr_q[1:0] == `SPCR_MODE_PDOWN) && !o_chip_reset
      |=> o_power_down ##1 (o_power_down || pwr_q[1:0] != `SPCR_MODE_PDOWN))
      else $error("power down not entered");
   a_normal_map: assert property ((pwr_q[1:0] == `SPCR_MODE_NORMAL) && !o_chip_reset
      |=> !o_power_down && o_operating_mode == `SPCR_MODE_NORMAL)
      else $error("normal operation not selected");
   a_rsvd_store: assert property ((wr_en && addr == `SPCR_ADDR_PWR && !o_chip_reset)
      |=> pwr_q == $past(next_shreg[7:0]))
      else $error("power register write lost");
endmodule
`default_nettype wire

// ---- verilog/spcr_params.svh ----
// Purpose: Named constants for the serial configuration register bank.
// Assumes: Included by its bare name from the package and the design files.
// Notes: Addresses are the 15-bit register addresses carried in the instruction word.
`ifndef SPCR_PARAMS_SVH
`define SPCR_PARAMS_SVH

// Register addresses.
`define SPCR_ADDR_CFG 15'h0000
`define SPCR_ADDR_PWR 15'h0002
`define SPCR_ADDR_CLASS 15'h0003
`define SPCR_ADDR_HOLD 15'h0010

// Reset values and the read value of unmapped addresses.
`define SPCR_RST_CFG 8'h30
`define SPCR_RST_PWR 8'h00
`define SPCR_RST_CLASS 8'h00
`define SPCR_RST_HOLD 8'h00
`define SPCR_RD_UNMAPPED 8'h00

// Field positions and codes.
`define SPCR_BIT_SRST 7
`define SPCR_BIT_ASCEND 5
`define SPCR_BIT_HOLD 0
`define SPCR_BIT_OUTFLAG 4
`define SPCR_MODE_NORMAL 2'h0
`define SPCR_MODE_PDOWN 2'h3
// Device-class code; the value is arbitrary.
`define SPCR_CLASS_CODE 4'hA

// Serial framing: 16 instruction bits, then 8-bit data bytes.
`define SPCR_INSTR_LAST 5'h0F
`define SPCR_BYTE_LAST 5'h07
`define SPCR_BIT_RW 15

// Soft reset timing.
`define SPCR_SRST_NS 750
`define SPCR_CLK_NS 5
`define SPCR_SRST_CYC ((`SPCR_SRST_NS) / (`SPCR_CLK_NS))
`define SPCR_SRST_LOAD 8'(`SPCR_SRST_CYC - 2)
`define SPCR_CNT_ZERO 8'h00
`define SPCR_CNT_ONE 8'h01

`endif

// ---- verilog/spcr_pkg.sv ----
// Purpose: Types shared by the serial configuration register bank.
// Assumes: Constants come from spcr_params.svh.
// Notes: Holds only the serial engine state type.
`default_nettype none
`include "spcr_params.svh"
package spcr_pkg;
   // Serial engine phase within one chip-select frame.
   typedef enum logic {SPCR_INSTR, SPCR_DATA} spcr_phase_t;
endpackage
`default_nettype wire

// ---- verilog/spcr_reg8.sv ----
// Purpose: One 8-bit writable register with a synchronous clear.
// Assumes: Single clock, asynchronous active-low reset.
// Notes: The clear wins over a write so a soft reset leaves the reset value.
`timescale 1ns/1ps
`default_nettype none
module spcr_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   // Clock and reset.
   input wire logic i_clk,
   input wire logic i_arst_n,
   // Control.
   input wire logic i_clr,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   // Stored value.
   output logic [7:0] o_q
);
   // Clear has priority so no write can survive the soft reset window.
   always_ff @(posedge i_clk or negedge i_arst_n)
   begin
      if (!i_arst_n)
         o_q <= RESET_VAL;
      else if (i_clr)
         o_q <= RESET_VAL;
      else if (i_we)
         o_q <= i_wdata;
   end
endmodule
`default_nettype wire

// ---- test/spcr_host_model.sv ----
// Purpose: Behavioural serial host that frames mode 0 transfers for the register bank.
// Assumes: Serial clock high and low for three system cycles each.
// Notes: Write data comes from wb, read data lands in rb, one byte per entry.
`timescale 1ns/1ps
`default_nettype none
module spcr_host_model (
   // Clock.
   input wire logic i_clk,
   // Lines from the device.
   input wire logic i_sdo,
   input wire logic i_sdo_oe_n,
   // Lines to the device; the data line is output only, no three-wire mode.
   output var logic o_sclk,
   output var logic o_cs_n,
   output var logic o_sdi
);
   logic [7:0] wb [0:3];
   logic [7:0] rb [0:3];

   // Idle levels before the first frame.
   initial
   begin
      o_sclk = 1'b0;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end

   // One bit: data set with the clock low, read data taken just before the rise.
   task automatic bit_x(input logic d, output logic q);
      @(posedge i_clk);
      #1;
      o_sdi = d;
      o_sclk = 1'b0;
      repeat (3) @(posedge i_clk);
      #1;
      q = (i_sdo_oe_n === 1'b0) ? i_sdo : 1'bx;
      o_sclk = 1'b1;
      repeat (2) @(posedge i_clk);
   endtask

   // Whole frame: read flag, 15-bit address, then n whole bytes, MSB first.
   task automatic xfer(input logic rd, input logic [14:0] addr, input int n);
      logic [15:0] ins;
      logic q;
      ins = {rd, addr};
      @(posedge i_clk);
      #1;
      o_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--) bit_x(ins[i], q);
      for (int b = 0; b < n; b++)
         for (int i = 7; i >= 0; i--)
         begin
            bit_x(wb[b][i], q);
            rb[b][i] = q;
         end
      @(posedge i_clk);
      #1;
      o_sclk = 1'b0;
      o_sdi = ~o_sdi; // Released data shows the inverse, never a stale copy.
      repeat (2) @(posedge i_clk);
      #1;
      o_cs_n = 1'b1;
      repeat (4) @(posedge i_clk);
   endtask
endmodule
`default_nettype wire

// ---- test/tb_top.sv ----
// Purpose: Self-checking bench of the register bank against a register model.
// Assumes: Host model frames every transfer; no frame during a soft reset.
// Notes: Random data keeps the mode field at 0 or 3 and bit 7 clear.
`timescale 1ns/1ps
`default_nettype none
`include "spcr_params.svh"
module tb_top;
   logic i_clk = 1'b0;
   logic i_arst_n = 1'b0;
   logic sclk, cs_n, sdi, sdo, sdo_oe_n, chip_reset, power_down;
   logic [1:0] mode;
   logic [7:0] m_cfg, m_pwr, m_cls, m_hold;
   logic [14:0] a;
   logic [14:0] tbl [0:5] = '{15'h0000, 15'h0002, 15'h0003, 15'h0010, 15'h0001, 15'h7FFF};
   int n_fail = 0, total_checks = 0, seed = 32'hAB0F, cyc = 0, rst_len = 0;

   // 200 MHz system clock.
   always #2.5 i_clk = ~i_clk;

   spcr_bank DUT (.i_clk(i_clk), .i_arst_n(i_arst_n), .i_sclk(sclk), .i_cs_n(cs_n),
      .i_sdi(sdi), .o_sdo(sdo), .o_sdo_oe_n(sdo_oe_n), .o_chip_reset(chip_reset),
      .o_power_down(power_down), .o_operating_mode(mode));
   spcr_host_model host (.i_clk(i_clk), .i_sdo(sdo), .i_sdo_oe_n(sdo_oe_n),
      .o_sclk(sclk), .o_cs_n(cs_n), .o_sdi(sdi));

   task automatic conclude;
      $display("checks %0d, mismatches %0d", total_checks, n_fail);
      if (n_fail == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask

   task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
      total_checks++;
      if (got !== exp)
      begin
         n_fail++;
         $display("[ERR] %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Register model; bit 4 of the config always one, class code fixed.
   task automatic m_init;
      m_cfg = `SPCR_RST_CFG;
      m_pwr = `SPCR_RST_PWR;
      m_cls = `SPCR_RST_CLASS;
      m_hold = `SPCR_RST_HOLD;
   endtask

   function automatic logic [7:0] mr(input logic [14:0] p);
      case (p)
         `SPCR_ADDR_CFG: mr = m_cfg;
         `SPCR_ADDR_PWR: mr = m_pwr;
         `SPCR_ADDR_CLASS: mr = {m_cls[7:4], `SPCR_CLASS_CODE};
         `SPCR_ADDR_HOLD: mr = m_hold;
         default: mr = `SPCR_RD_UNMAPPED;
      endcase
   endfunction

   task automatic mw(input logic [14:0] p, input logic [7:0] d);
      case (p)
         `SPCR_ADDR_CFG: m_cfg = {1'b0, d[6:5], 1'b1, d[3:0]};
         `SPCR_ADDR_PWR: m_pwr = d;
         `SPCR_ADDR_CLASS: m_cls = d;
         `SPCR_ADDR_HOLD: m_hold = d;
         default: ;
      endcase
   endtask

   // Single-byte write with fixed data, mirrored into the model.
   task automatic put(input logic [14:0] p, input logic [7:0] d);
      host.wb[0] = d;
      host.xfer(1'b0, p, 1);
      mw(p, d);
   endtask

   // Frame through the host; writes update the model, reads compare every byte.
   task automatic frame(input logic rd, input logic [14:0] p0, input int n);
      logic [14:0] p;
      logic [7:0] r;
      for (int b = 0; b < n; b++)
      begin
         r = $random(seed);
         host.wb[b] = {1'b0, r[6:2], r[0], r[0]};
      end
      host.xfer(rd, p0, n);
      p = p0;
      for (int b = 0; b < n; b++)
      begin
         if (rd)
            chk("read byte", mr(p), host.rb[b]);
         else
            mw(p, host.wb[b]);
         p = m_hold[0] ? p : (m_cfg[5] ? p + 15'h0001 : p - 15'h0001);
      end
   endtask

   task automatic rd_all;
      for (int k = 0; k < 5; k++) frame(1'b1, tbl[k], 1);
      chk("mode", {6'h00, m_pwr[1:0]}, {6'h00, mode});
      chk("power down", {7'h00, m_pwr[1:0] == 2'h3}, {7'h00, power_down});
   endtask

   // Soft reset length and a cut-off for a hung run.
   always @(posedge i_clk)
   begin
      cyc++;
      if (chip_reset === 1'b1)
         rst_len++;
      if (cyc == 40000)
      begin
         n_fail++;
         $display("[ERR] run time expected below 40000 seen %0d", cyc);
         conclude();
      end
   end

   initial
   begin
      m_init();
      repeat (10) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      repeat (2) @(posedge i_clk);
      rd_all();
      $display("test reset values done");
      // Random writes and streams in whatever stepping mode they leave.
      repeat (16)
      begin
         a = tbl[{$random(seed)} % 6];
         frame(1'b0, a, 1);
         rd_all();
         frame(1'b1, tbl[{$random(seed)} % 6], 4);
         a = (m_cfg[5] | m_hold[0]) ? `SPCR_ADDR_PWR : `SPCR_ADDR_CLASS;
         frame(1'b0, a, 3);
         frame(1'b1, a, 3);
      end
      $display("test random access and streaming done");
      // Fixed-address and descending streams, each mode first set by an explicit write.
      put(`SPCR_ADDR_HOLD, 8'h01);
      frame(1'b0, `SPCR_ADDR_PWR, 3);
      frame(1'b1, `SPCR_ADDR_PWR, 3);
      put(`SPCR_ADDR_HOLD, 8'h00);
      put(`SPCR_ADDR_CFG, 8'h00);
      frame(1'b0, `SPCR_ADDR_CLASS, 3);
      frame(1'b1, `SPCR_ADDR_CLASS, 3);
      $display("test fixed and descending streams done");
      host.wb[0] = 8'h03;
      host.xfer(1'b0, `SPCR_ADDR_PWR, 1);
      rst_len = 0;
      host.wb[0] = 8'h80;
      host.xfer(1'b0, `SPCR_ADDR_CFG, 1);
      repeat (`SPCR_SRST_CYC) @(posedge i_clk);
      #1;
      chk("reset length", 8'(`SPCR_SRST_CYC - 1), 8'(rst_len));
      chk("chip reset", 8'h00, {7'h00, chip_reset});
      m_init();
      rd_all();
      $display("test soft reset done");
      frame(1'b0, `SPCR_ADDR_HOLD, 1);
      host.wb[0] = 8'h03;
      host.xfer(1'b0, `SPCR_ADDR_PWR, 1);
      #1 i_arst_n = 1'b0;
      repeat (3) @(posedge i_clk);
      #1 i_arst_n = 1'b1;
      repeat (2) @(posedge i_clk);
      m_init();
      rd_all();
      $display("test mid-run reset done");
      conclude();
   end
endmodule
`default_nettype wire
